/* slrc_top.sv */
// slrc_top: configuration registers of the serial link receiver
// assumes: avalon-mm master on clk_in; lane status and mode figures on clk_in
// Operation
// - enable bit low holds receiver subsystem in reset and serdes phy off
// - disabled link holds local multiframe counter in reset
// - six-bit link mode field, reset zero, written whether the link is enabled or disabled
// - four-bit stream count field resets to one, sets enabled streams
// - lanes equal ceiling of streams over mode maximum times mode lanes, capped at 16
// - control bit 6 selects vendor transmitter compatibility mode
// - bit 5 low releases buffer once every enabled lane is writing
// - bit 5 high releases buffer at counter-derived release opportunity
// - control bit 4 selects 8b/10b or 64b/66b link layer
// - control bit 1 selects offset binary or two's complement samples
// - control bit 0 enables 8b/10b descrambling, reset one
// - 64b/66b modes always descramble regardless of scrambler bit
// - each release delay step postpones opportunities by four octets
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module slrc_top (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // avalon-mm slave
  input  wire logic [11:0] avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // mode figures and lane status
  input  wire logic [3:0]  mode_max_streams_in,
  input  wire logic [4:0]  mode_lane_count_in,
  input  wire logic [9:0]  multiframe_octets_in,
  input  wire logic [15:0] lane_writing_in,
  // receiver controls
  output logic             subsystem_reset_out,
  output logic             phy_enable_out,
  output logic [15:0]      lane_enable_out,
  output logic             vendor_transmitter_mode_out,
  output logic             encoding_64b66b_out,
  output logic             sample_twos_comp_out,
  output logic             descramble_enable_out,
  output logic             buffer_release_out
);
  // registers
  logic [7:0]  enable_reg,  enable_next;
  logic [7:0]  mode_reg,    mode_next;
  logic [7:0]  streams_reg, streams_next;
  logic [7:0]  control_reg, control_next;
  logic [7:0]  rbd_reg,     rbd_next;
  logic        wait_reg,    wait_next;
  logic [31:0] rdata_reg,   rdata_next;
  logic [2:0]  div_reg,     div_next;
  logic        tick_reg,    tick_next;
  logic        release_reg, release_next;
  logic [15:0] lanes_en_reg, lanes_en_next;
  logic        ctl_reset_reg, ctl_phy_reg, ctl_vendor_reg, ctl_enc_reg, ctl_fmt_reg, ctl_descr_reg;
  logic [9:0]  index;
  logic        access;
  logic        do_write;
  logic        link_on;
  logic        opportunity;
  logic        all_writing;
  logic [4:0]  lane_total;
  logic [15:0] active_mask;

  assign index    = avs_address_in[11:2];
  assign access   = avs_read_in | avs_write_in;
  assign do_write = avs_write_in & ~wait_reg & avs_byteenable_in[0];
  assign link_on  = enable_reg[slrc_pkg::BIT_SUBSYSTEM_ENABLE];

  // lane count from stream count and mode figures
  slrc_lane_calc u_lane_calc (
    .clk_in              (clk_in),
    .resetn_in           (resetn_in),
    .stream_count_in     (streams_reg[slrc_pkg::STREAM_MSB:0]),
    .mode_max_streams_in (mode_max_streams_in),
    .mode_lane_count_in  (mode_lane_count_in),
    .lane_total_out      (lane_total)
  );

  // multiframe counter and release opportunities
  slrc_release_timer u_release_timer (
    .clk_in                  (clk_in),
    .resetn_in               (resetn_in),
    .run_in                  (link_on),
    .octet_tick_in           (tick_reg),
    .multiframe_octets_in    (multiframe_octets_in),
    .release_buffer_delay_in (rbd_reg[slrc_pkg::RBD_MSB:0]),
    .opportunity_out         (opportunity)
  );

  // active lane mask, one bit per lane
  genvar gi;
  generate
    for (gi = 0; gi < slrc_pkg::NUM_LANES; gi++) begin : g_lane
      assign active_mask[gi] = (5'(gi) < lane_total);
    end
  endgenerate

  // only lanes already switched on count: a lane not yet enabled shows no real status
  assign all_writing = (lanes_en_reg != 16'h0000) && ((lane_writing_in & lanes_en_reg) == lanes_en_reg);

  // bus slave: one wait cycle, then write takes effect and read data stand
  always_comb begin
    enable_next  = enable_reg;
    mode_next    = mode_reg;
    streams_next = streams_reg;
    control_next = control_reg;
    rbd_next     = rbd_reg;
    wait_next    = ~(access & wait_reg);
    rdata_next   = rdata_reg;
    if (access & wait_reg) begin
      unique case (index)
        slrc_pkg::IDX_LINK_SUBSYSTEM_ENABLE: rdata_next = {24'h000000, enable_reg};
        slrc_pkg::IDX_LINK_MODE_SELECT:      rdata_next = {24'h000000, mode_reg};
        slrc_pkg::IDX_STREAM_COUNT_CONFIG:   rdata_next = {24'h000000, streams_reg};
        slrc_pkg::IDX_LINK_CONTROL:          rdata_next = {24'h000000, control_reg};
        slrc_pkg::IDX_RELEASE_BUFFER_DELAY:  rdata_next = {24'h000000, rbd_reg};
        slrc_pkg::IDX_RECEIVER_STATUS:       rdata_next = {26'h0000000, release_reg, lane_total};
        default:                             rdata_next = 32'h00000000;
      endcase
    end
    // full bytes stored, reserved bits included
    if (do_write) begin
      unique case (index)
        slrc_pkg::IDX_LINK_SUBSYSTEM_ENABLE: enable_next  = avs_writedata_in[7:0];
        slrc_pkg::IDX_LINK_MODE_SELECT:      mode_next    = avs_writedata_in[7:0];
        slrc_pkg::IDX_STREAM_COUNT_CONFIG:   streams_next = avs_writedata_in[7:0];
        slrc_pkg::IDX_LINK_CONTROL:          control_next = avs_writedata_in[7:0];
        slrc_pkg::IDX_RELEASE_BUFFER_DELAY:  rbd_next     = avs_writedata_in[7:0];
        default:                             rbd_next     = rbd_reg;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      enable_reg  <= slrc_pkg::RST_LINK_SUBSYSTEM_ENABLE;
      mode_reg    <= slrc_pkg::RST_LINK_MODE_SELECT;
      streams_reg <= slrc_pkg::RST_STREAM_COUNT_CONFIG;
      control_reg <= slrc_pkg::RST_LINK_CONTROL;
      rbd_reg     <= slrc_pkg::RST_RELEASE_BUFFER_DELAY;
      wait_reg    <= 1'b1;
      rdata_reg   <= 32'h00000000;
    end else begin
      enable_reg  <= enable_next;
      mode_reg    <= mode_next;
      streams_reg <= streams_next;
      control_reg <= control_next;
      rbd_reg     <= rbd_next;
      wait_reg    <= wait_next;
      rdata_reg   <= rdata_next;
    end
  end

  // octet enable divider and elastic buffer release
  always_comb begin
    div_next     = div_reg + 3'h1;
    tick_next    = 1'b0;
    if (div_reg == slrc_pkg::OCTET_DIV - 3'h1) begin
      div_next  = 3'h0;
      tick_next = 1'b1;
    end
    release_next = release_reg;
    if (!link_on) begin
      release_next = 1'b0;
    end else if (!release_reg && all_writing) begin
      if (!control_reg[slrc_pkg::BIT_RELEASE_CLASS]) begin
        release_next = 1'b1;
      end else if (opportunity) begin
        release_next = 1'b1;
      end
    end
    lanes_en_next = link_on ? active_mask : 16'h0000;
  end

  // registered control outputs
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_reg        <= 3'h0;
      tick_reg       <= 1'b0;
      release_reg    <= 1'b0;
      lanes_en_reg   <= 16'h0000;
      ctl_reset_reg  <= 1'b1;
      ctl_phy_reg    <= 1'b0;
      ctl_vendor_reg <= 1'b0;
      ctl_enc_reg    <= 1'b0;
      ctl_fmt_reg    <= 1'b1;
      ctl_descr_reg  <= 1'b1;
    end else begin
      div_reg        <= div_next;
      tick_reg       <= tick_next;
      release_reg    <= release_next;
      lanes_en_reg   <= lanes_en_next;
      ctl_reset_reg  <= ~link_on;
      ctl_phy_reg    <= link_on;
      ctl_vendor_reg <= control_reg[slrc_pkg::BIT_VENDOR_MODE];
      ctl_enc_reg    <= control_reg[slrc_pkg::BIT_ENCODING];
      ctl_fmt_reg    <= control_reg[slrc_pkg::BIT_SAMPLE_FORMAT];
      ctl_descr_reg  <= control_reg[slrc_pkg::BIT_ENCODING] | control_reg[slrc_pkg::BIT_SCRAMBLER];
    end
  end

  assign avs_readdata_out            = rdata_reg;
  assign avs_waitrequest_out         = wait_reg;
  assign subsystem_reset_out         = ctl_reset_reg;
  assign phy_enable_out              = ctl_phy_reg;
  assign lane_enable_out             = lanes_en_reg;
  assign vendor_transmitter_mode_out = ctl_vendor_reg;
  assign encoding_64b66b_out         = ctl_enc_reg;
  assign sample_twos_comp_out        = ctl_fmt_reg;
  assign descramble_enable_out       = ctl_descr_reg;
  assign buffer_release_out          = release_reg;

  // checks
  sequence write_ctl_s;
    do_write && index == slrc_pkg::IDX_LINK_CONTROL;
  endsequence

  subsystem_reset_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !link_on |=> subsystem_reset_out && !phy_enable_out && lane_enable_out == 16'h0000)
    else $error("subsystem not held while disabled");
  mode_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    do_write && index == slrc_pkg::IDX_LINK_MODE_SELECT |=> mode_reg == $past(avs_writedata_in[7:0]))
    else $error("mode field not stored");
  stream_store_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    do_write && index == slrc_pkg::IDX_STREAM_COUNT_CONFIG |=> streams_reg[3:0] == $past(avs_writedata_in[3:0]))
    else $error("stream count not stored");
  vendor_mode_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    write_ctl_s |=> ##1 vendor_transmitter_mode_out == $past(avs_writedata_in[6], 2))
    else $error("vendor mode output wrong");
  immediate_release_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    link_on && !control_reg[5] && all_writing && !release_reg |=> buffer_release_out)
    else $error("buffer not released when lanes writing");
  timed_release_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(buffer_release_out) && $past(control_reg[5]) |-> $past(opportunity))
    else $error("release outside an opportunity");
  encoding_sel_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    write_ctl_s |=> ##1 encoding_64b66b_out == $past(avs_writedata_in[4], 2))
    else $error("encoding output wrong");
  sample_format_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    write_ctl_s |=> ##1 sample_twos_comp_out == $past(avs_writedata_in[1], 2))
    else $error("sample format output wrong");
  descramble_sel_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !control_reg[4] |=> descramble_enable_out == $past(control_reg[0]))
    else $error("8b10b descramble not following bit");
  always_scrambled_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    control_reg[4] |=> descramble_enable_out)
    else $error("64b66b lanes not descrambled");
  reserved_store_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    do_write && index == slrc_pkg::IDX_LINK_SUBSYSTEM_ENABLE |=> enable_reg == $past(avs_writedata_in[7:0]))
    else $error("reserved bits not stored");
endmodule // slrc_top
`default_nettype wire

/* slrc_pkg.sv */
// slrc_pkg: constants for the serial link receiver configuration bank
// assumes: registers sit on 32-bit avalon words, byte address = 4 * index
package slrc_pkg;
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_LINK_SUBSYSTEM_ENABLE = 10'h100;
  localparam logic [9:0] IDX_LINK_MODE_SELECT      = 10'h101;
  localparam logic [9:0] IDX_STREAM_COUNT_CONFIG   = 10'h102;
  localparam logic [9:0] IDX_LINK_CONTROL          = 10'h103;
  localparam logic [9:0] IDX_RELEASE_BUFFER_DELAY  = 10'h104;
  localparam logic [9:0] IDX_RECEIVER_STATUS       = 10'h105;
  // reset values
  localparam logic [7:0] RST_LINK_SUBSYSTEM_ENABLE = 8'h00;
  localparam logic [7:0] RST_LINK_MODE_SELECT      = 8'h00;
  localparam logic [7:0] RST_STREAM_COUNT_CONFIG   = 8'h01;
  localparam logic [7:0] RST_LINK_CONTROL          = 8'h03;
  localparam logic [7:0] RST_RELEASE_BUFFER_DELAY  = 8'h00;
  // field positions
  localparam int BIT_SUBSYSTEM_ENABLE = 0;
  localparam int BIT_VENDOR_MODE      = 6;
  localparam int BIT_RELEASE_CLASS    = 5;
  localparam int BIT_ENCODING         = 4;
  localparam int BIT_SAMPLE_FORMAT    = 1;
  localparam int BIT_SCRAMBLER        = 0;
  localparam int MODE_MSB             = 5;
  localparam int STREAM_MSB           = 3;
  localparam int RBD_MSB              = 5;
  // lanes and octet timing
  localparam int NUM_LANES            = 16;
  localparam logic [2:0] OCTET_DIV    = 3'h4;   // clk cycles per octet
  localparam int OCTETS_PER_RBD_STEP  = 4;
endpackage : slrc_pkg

/* slrc_lane_calc.sv */
// slrc_lane_calc: lanes to enable from stream count and mode figures
// assumes: mode figures come from the mode decoder on the same clock
`timescale 1ns/100ps
`default_nettype none
module slrc_lane_calc (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // operands
  input  wire logic [3:0] stream_count_in,
  input  wire logic [3:0] mode_max_streams_in,
  input  wire logic [4:0] mode_lane_count_in,
  // result
  output logic      [4:0] lane_total_out
);
  logic [4:0] lanes_reg;
  logic [4:0] lanes_next;
  logic [4:0] groups;
  logic [9:0] product;

  // ceiling of streams over max streams, times lanes per group
  always_comb begin
    groups = 5'h00;
    if (mode_max_streams_in != 4'h0) begin
      groups = 5'((5'(stream_count_in) + 5'(mode_max_streams_in) - 5'h01) / 5'(mode_max_streams_in));
    end
    product    = 10'(groups) * 10'(mode_lane_count_in); // widen first so the product cannot wrap at five bits
    lanes_next = (product > 10'(slrc_pkg::NUM_LANES)) ? 5'(slrc_pkg::NUM_LANES) : product[4:0];
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lanes_reg <= 5'h00;
    end else begin
      lanes_reg <= lanes_next;
    end
  end

  assign lane_total_out = lanes_reg;

  lane_ceiling_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (mode_max_streams_in == 4'h1 && mode_lane_count_in == 5'h01 && stream_count_in != 4'h0)
    |=> lane_total_out == 5'($past(stream_count_in)))
    else $error("lane count not ceiling of streams");
endmodule // slrc_lane_calc
`default_nettype wire

/* slrc_release_timer.sv */
// slrc_release_timer: local multiframe counter and release opportunities
// assumes: octet_tick_in is a one-cycle enable, multiframe length nonzero
`timescale 1ns/100ps
`default_nettype none
module slrc_release_timer (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  // control
  input  wire logic       run_in,
  input  wire logic       octet_tick_in,
  input  wire logic [9:0] multiframe_octets_in,
  input  wire logic [5:0] release_buffer_delay_in,
  // result
  output logic            opportunity_out
);
  logic [9:0] count_reg;
  logic [9:0] count_next;
  logic       opp_reg;
  logic       opp_next;
  logic [9:0] target;

  // counter held at zero while the link is off, wraps at the multiframe
  always_comb begin
    target     = 10'(release_buffer_delay_in * slrc_pkg::OCTETS_PER_RBD_STEP);
    count_next = count_reg;
    opp_next   = 1'b0;
    if (!run_in) begin
      count_next = 10'h000;
    end else if (octet_tick_in) begin
      opp_next   = (count_reg == target);
      count_next = (count_reg + 10'h001 >= multiframe_octets_in) ? 10'h000 : count_reg + 10'h001;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg <= 10'h000;
      opp_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      opp_reg   <= opp_next;
    end
  end

  assign opportunity_out = opp_reg;

  counter_held_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !run_in |=> count_reg == 10'h000 && !opportunity_out)
    else $error("multiframe counter ran while disabled");
  delay_offset_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    opportunity_out |-> $past(count_reg) == 10'($past(release_buffer_delay_in) * 4))
    else $error("opportunity not at delay times four octets");
endmodule // slrc_release_timer
`default_nettype wire

/* slrc_tx_model.sv */
// slrc_tx_model: far-side transmitter, its lanes begin elastic buffer writes one after another
// assumes: link_up_in is high while the receiver subsystem is out of reset
`timescale 1ns/100ps
`default_nettype none
module slrc_tx_model (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // control
  input  wire logic        link_up_in,
  input  wire logic        hold_lane0_in,
  input  wire logic [15:0] lane_enable_in,
  // lane status
  output logic      [15:0] lane_writing_out
);
  logic [7:0]  age_reg;
  logic [15:0] noise_reg;
  // cycles since link up, and a pattern that toggles every cycle for idle lanes
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      age_reg   <= 8'h00;
      noise_reg <= 16'h5a5a;
    end else begin
      age_reg   <= link_up_in ? ((age_reg == 8'hff) ? age_reg : age_reg + 8'h01) : 8'h00;
      noise_reg <= ~noise_reg;
    end
  end
  // lane i starts writing i+2 cycles after link up; lanes not in use show no steady level
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (lane_enable_in[i] && link_up_in)
        lane_writing_out[i] = (age_reg > 8'(i + 1)) && !(i == 0 && hold_lane0_in);
      else
        lane_writing_out[i] = noise_reg[i];
    end
  end
endmodule // slrc_tx_model
`default_nettype wire

/* slrc_top_tb.sv */
// slrc_top_tb: self-checking bench for the receiver configuration registers
// assumes: master waits on waitrequest, outputs settle within two cycles of a write
`timescale 1ns/100ps
`default_nettype none
module slrc_top_tb;
  typedef struct {logic [7:0] ctrl; logic [3:0] m, mx; logic [4:0] lx; logic [3:0] outs; logic [4:0] lanes;} slrc_row_type;
  logic clk_in, resetn_in, avs_read_in, avs_write_in, avs_waitrequest_out, hold;
  logic [11:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  logic [3:0]  avs_byteenable_in, mode_max_streams_in;
  logic [4:0]  mode_lane_count_in;
  logic [9:0]  multiframe_octets_in;
  logic [15:0] lane_writing_in, lane_enable_out;
  logic        subsystem_reset_out, phy_enable_out, vendor_out, enc_out, fmt_out, descr_out, release_out;
  int          errors, compares, n0, n4, n6, n4b;
  slrc_row_type rows [7] = '{
    '{8'h00, 4'h1, 4'h2, 5'h04, 4'h0, 5'h04}, '{8'h01, 4'h8, 4'h2, 5'h01, 4'h1, 5'h04},
    '{8'h02, 4'h3, 4'h2, 5'h02, 4'h2, 5'h04}, '{8'h10, 4'h8, 4'h8, 5'h10, 4'h5, 5'h10},
    '{8'h40, 4'h8, 4'h2, 5'h08, 4'h8, 5'h10}, '{8'h9c, 4'h2, 4'h0, 5'h04, 4'h5, 5'h00},
    '{8'h03, 4'h3, 4'h1, 5'h01, 4'h3, 5'h03}};
  // design and far-side model
  slrc_top dut (.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .mode_max_streams_in(mode_max_streams_in),
    .mode_lane_count_in(mode_lane_count_in), .multiframe_octets_in(multiframe_octets_in),
    .lane_writing_in(lane_writing_in), .subsystem_reset_out(subsystem_reset_out),
    .phy_enable_out(phy_enable_out), .lane_enable_out(lane_enable_out),
    .vendor_transmitter_mode_out(vendor_out), .encoding_64b66b_out(enc_out),
    .sample_twos_comp_out(fmt_out), .descramble_enable_out(descr_out), .buffer_release_out(release_out));
  slrc_tx_model tx (.clk_in(clk_in), .resetn_in(resetn_in), .link_up_in(!subsystem_reset_out),
    .hold_lane0_in(hold), .lane_enable_in(lane_enable_out), .lane_writing_out(lane_writing_in));
  // clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // verdict and end of run
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one comparison
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic is_wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
    int k;
    k = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h000000, d};
    avs_byteenable_in <= be;
    avs_read_in <= !is_wr;
    avs_write_in <= is_wr;
    // read right after the edge, so the values seen are those that stood at it
    do begin
      @(posedge clk_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 20);
    if (avs_waitrequest_out !== 1'b0) begin
      check(1'b0, 1'b1, "bus timeout");
      complete_run();
    end
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input string what);
    bus(1'b0, a, 8'h00, 4'h1);
    check(q, {24'h000000, exp}, what);
  endtask
  task automatic settle();
    repeat (3) @(negedge clk_in);
  endtask
  // registers and outputs at their reset values
  task automatic check_reset_values();
    check({subsystem_reset_out, phy_enable_out, release_out, lane_enable_out}, {3'b100, 16'h0000}, "reset out");
    check({vendor_out, enc_out, fmt_out, descr_out}, 4'h3, "reset ctrl out");
    rdc(12'h400, slrc_pkg::RST_LINK_SUBSYSTEM_ENABLE, "rst enable");
    rdc(12'h404, slrc_pkg::RST_LINK_MODE_SELECT, "rst mode");
    rdc(12'h408, slrc_pkg::RST_STREAM_COUNT_CONFIG, "rst streams");
    rdc(12'h40c, slrc_pkg::RST_LINK_CONTROL, "rst control");
    $display("test reset values done");
  endtask
  // disabled reconfiguration, then enable; cycles until buffer release
  task automatic measure(input logic [7:0] ctrl, input logic [7:0] release_buffer_delay, input logic must, output int n);
    wr(12'h400, 8'h00);
    wr(12'h40c, ctrl);
    wr(12'h410, release_buffer_delay);
    wr(12'h400, 8'h01);
    n = 0;
    while (release_out !== 1'b1 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 400 && must) begin
      check(1'b0, 1'b1, "release timeout");
      complete_run();
    end
  endtask
  // main sequence
  initial begin
    errors = 0;
    compares = 0;
    hold = 1'b0;
    resetn_in = 1'b0;
    {avs_read_in, avs_write_in} = 2'b00;
    avs_address_in = 12'h000;
    avs_writedata_in = 32'h0;
    avs_byteenable_in = 4'h1;
    mode_max_streams_in = 4'h2;
    mode_lane_count_in = 5'h04;
    multiframe_octets_in = 10'h020;
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(negedge clk_in);
    check_reset_values();
    // ordinary cases: control bits and lane count per row
    foreach (rows[i]) begin
      wr(12'h400, 8'h00);
      wr(12'h40c, rows[i].ctrl);
      wr(12'h408, {4'h0, rows[i].m});
      @(posedge clk_in);
      mode_max_streams_in <= rows[i].mx;
      mode_lane_count_in <= rows[i].lx;
      wr(12'h400, 8'h01);
      settle();
      check({vendor_out, enc_out, fmt_out, descr_out}, rows[i].outs, "ctrl outputs");
      check({subsystem_reset_out, phy_enable_out}, 2'b01, "enabled");
      check(lane_enable_out, 16'((32'h1 << rows[i].lanes) - 32'h1), "lanes");
      rdc(12'h40c, rows[i].ctrl, "ctrl readback");
      bus(1'b0, 12'h414, 8'h00, 4'h1);
      check(q[4:0], rows[i].lanes, "lane total");
    end
    $display("test table done");
    // unmapped address, masked byte write, reserved mode bits
    wr(12'h7fc, 8'hff);
    rdc(12'h7fc, 8'h00, "unmapped");
    wr(12'h404, 8'hc5);
    bus(1'b1, 12'h404, 8'h3a, 4'h0);
    rdc(12'h404, 8'hc5, "mode byteenable");
    $display("test access done");
    // disable holds the subsystem in reset
    wr(12'h400, 8'h00);
    settle();
    check({subsystem_reset_out, phy_enable_out, release_out}, 3'b100, "disabled");
    @(posedge clk_in);
    mode_max_streams_in <= 4'h2;
    mode_lane_count_in <= 5'h04;
    wr(12'h408, 8'h02);
    // buffer release classes and delay steps
    measure(8'h03, 8'h00, 1'b1, n0);
    check(n0 < 16, 1'b1, "immediate release");
    // the first timed release fixes the octet phase that the three after it share
    measure(8'h23, 8'h04, 1'b1, n4b);
    check(n4b > n0 + 20, 1'b1, "opportunity release");
    measure(8'h23, 8'h04, 1'b1, n4);
    measure(8'h23, 8'h06, 1'b1, n6);
    measure(8'h23, 8'h04, 1'b1, n4b);
    check(n6 - n4, 32'd32, "delay step");
    check(n4b, n4, "counter restart");
    $display("test release done");
    // one lane late: no release until it writes
    hold = 1'b1;
    measure(8'h03, 8'h00, 1'b0, n0);
    check(n0 >= 400, 1'b1, "held release");
    hold = 1'b0;
    n0 = 0;
    while (release_out !== 1'b1 && n0 < 10) begin
      @(negedge clk_in);
      n0++;
    end
    check(release_out, 1'b1, "late release");
    if (release_out !== 1'b1)
      complete_run();
    $display("test late lane done");
    // reset in mid-run
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(negedge clk_in);
    check_reset_values();
    complete_run();
  end
endmodule // slrc_top_tb
`default_nettype wire
